// ### pts_pkg.sv
// pts_pkg: constants and types shared by the ptp stamp sideband block
// assumes a 32-bit apb register bus and byte-wide frame streams
package pts_pkg;
  // register byte offsets
  localparam logic [7:0] PTS_ADDR_RX_CFG = 8'h00;
  localparam logic [7:0] PTS_ADDR_TX_CFG = 8'h04;
  localparam logic [7:0] PTS_ADDR_RX_LATENCY = 8'h08;
  localparam logic [7:0] PTS_ADDR_STATUS = 8'h0c;
  localparam logic [7:0] PTS_ADDR_RX_FRAMES = 8'h10;
  // configuration fields
  localparam int PTS_CFG_INLINE_BIT = 22;
  localparam int PTS_RX_CFG_CF_BIT = 0;
  localparam int PTS_STAT_RX_BUSY_BIT = 0;
  localparam int PTS_STAT_TX_BUSY_BIT = 1;
  localparam int PTS_STAT_TAG_LSB = 16;
  // stamp layout
  localparam int PTS_NS_W = 32;
  localparam int PTS_SEC_W = 48;
  localparam int PTS_CF_W = 64;
  localparam int PTS_SEC_LSB = 32;
  localparam int PTS_CF_FRAC_W = 16;
  localparam logic [31:0] PTS_NS_PER_SEC = 32'h3b9a_ca00;
  localparam logic [2:0] PTS_STAMP_LAST = 3'h7;
  // transmit user sideband and command field layout
  localparam int PTS_TUSER_W = 128;
  localparam int PTS_TUSER_UNDERRUN = 0;
  localparam int PTS_TUSER_CMD_LSB = 64;
  localparam int PTS_CMD_OP_LSB = 0;
  localparam int PTS_CMD_CSUM_BIT = 8;
  localparam int PTS_CMD_TAG_LSB = 16;
  localparam int PTS_CMD_OFS_LSB = 32;
  localparam int PTS_CMD_CSUM_OFS_LSB = 48;
  localparam logic [1:0] PTS_OPC_ONE_STEP = 2'h1;
  localparam logic [1:0] PTS_OPC_TWO_STEP = 2'h2;

  typedef enum logic [1:0] {PTS_OP_NONE, PTS_OP_ONE_STEP, PTS_OP_TWO_STEP} pts_op_t;
endpackage

// ### pts_cmd_if.sv
// pts_cmd_if: carries a raw transmit command field to its decoder and back
// assumes both ends run on pclk
`timescale 1ns/10ps
`default_nettype none
interface pts_cmd_if;
  import pts_pkg::*;
  logic load;
  logic [63:0] field;
  logic valid;
  pts_op_t op;
  logic [15:0] tag;
  logic [15:0] offset;
  logic csum_update;
  logic [15:0] csum_offset;
  modport src (output load, field, input valid, op, tag, offset, csum_update, csum_offset);
  modport dec (input load, field, output valid, op, tag, offset, csum_update, csum_offset);
endinterface
`default_nettype wire

// ### pts_cmd_decode.sv
// pts_cmd_decode: registers the decoded fields of one transmit command field
// assumes load pulses once per frame with field stable in that cycle
`timescale 1ns/10ps
`default_nettype none
module pts_cmd_decode
  import pts_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command in, decoded out
  pts_cmd_if.dec cmd
);
  function automatic pts_op_t op_of(input logic [1:0] code);
    case (code)
      PTS_OPC_ONE_STEP: op_of = PTS_OP_ONE_STEP;
      PTS_OPC_TWO_STEP: op_of = PTS_OP_TWO_STEP;
      default: op_of = PTS_OP_NONE;
    endcase
  endfunction

  pts_op_t next_op;
  assign next_op = op_of(cmd.field[PTS_CMD_OP_LSB +: 2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd.valid <= 1'b0;
      cmd.op <= PTS_OP_NONE;
      cmd.tag <= 16'h0;
      cmd.offset <= 16'h0;
      cmd.csum_update <= 1'b0;
      cmd.csum_offset <= 16'h0;
    end else begin
      cmd.valid <= cmd.load;
      if (cmd.load) begin
        cmd.op <= next_op;
        cmd.tag <= (next_op != PTS_OP_NONE) ? cmd.field[PTS_CMD_TAG_LSB +: 16] : 16'h0;
        cmd.offset <= (next_op == PTS_OP_ONE_STEP) ?
          cmd.field[PTS_CMD_OFS_LSB +: 16] : 16'h0;
        cmd.csum_update <= (next_op == PTS_OP_ONE_STEP) & cmd.field[PTS_CMD_CSUM_BIT];
        cmd.csum_offset <= (next_op == PTS_OP_ONE_STEP && cmd.field[PTS_CMD_CSUM_BIT]) ?
          cmd.field[PTS_CMD_CSUM_OFS_LSB +: 16] : 16'h0;
      end
    end
  end

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RESERVED_OP_IS_NONE: assert property (
    cmd.load && cmd.field[PTS_CMD_OP_LSB +: 2] == 2'h3 |=> cmd.valid && cmd.op == PTS_OP_NONE)
    else $error("reserved op not decoded as no action");
  AST_TAG_RETURNED: assert property (
    cmd.load && cmd.field[PTS_CMD_OP_LSB +: 2] == PTS_OPC_TWO_STEP
    |=> cmd.tag == $past(cmd.field[PTS_CMD_TAG_LSB +: 16]))
    else $error("tag not returned for two-step command");
  AST_OFFSET_ONE_STEP: assert property (
    cmd.load && cmd.field[PTS_CMD_OP_LSB +: 2] == PTS_OPC_ONE_STEP
    |=> cmd.offset == $past(cmd.field[PTS_CMD_OFS_LSB +: 16]))
    else $error("one-step offset not taken from command");
endmodule // pts_cmd_decode
`default_nettype wire

// ### pts_top.sv
// pts_top: receive stamp adjust and delivery, transmit command field intake
// assumes one clock pclk that is also the mac receive clock, apb slave access
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pts_top
  import pts_pkg::*;
#(
  parameter logic [31:0] RX_LAT_RESET = 32'h0000_0040
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // time sources
  input wire logic [PTS_SEC_W-1:0] tod_sec,
  input wire logic [PTS_NS_W-1:0] tod_ns,
  input wire logic [PTS_CF_W-1:0] cf_time,
  // receive stream from mac
  input wire logic rx_capture,
  input wire logic [7:0] rx_in_data,
  input wire logic rx_in_valid,
  input wire logic rx_in_last,
  output logic rx_in_ready,
  // receive stream to client
  output logic [7:0] rx_out_data,
  output logic rx_out_valid,
  output logic rx_out_last,
  // receive stamp stream
  output logic [127:0] rx_stamp_stream_payload,
  output logic rx_stamp_stream_valid,
  // transmit stream from client
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_valid,
  input wire logic tx_in_last,
  input wire logic [PTS_TUSER_W-1:0] tx_in_user,
  output logic tx_in_ready,
  // transmit stream to mac
  output logic [7:0] tx_out_data,
  output logic tx_out_valid,
  output logic tx_out_last,
  output logic tx_out_underrun,
  input wire logic tx_out_ready,
  // decoded transmit command
  output logic tx_cmd_valid,
  output pts_op_t tx_cmd_op,
  output logic [15:0] tx_cmd_tag,
  output logic [15:0] tx_cmd_offset,
  output logic tx_cmd_csum_update,
  output logic [15:0] tx_cmd_csum_offset
);
  typedef enum logic [1:0] {RX_IDLE, RX_STAMP, RX_PASS} pts_rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_CMD, TX_PASS} pts_tx_state_t;

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      PTS_ADDR_RX_CFG, PTS_ADDR_TX_CFG, PTS_ADDR_RX_LATENCY,
      PTS_ADDR_STATUS, PTS_ADDR_RX_FRAMES: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  logic rx_cfg_inline;
  logic rx_cfg_cf;
  logic tx_cfg_inline;
  logic [31:0] rx_latency;
  logic [31:0] rx_frames;
  pts_rx_state_t rx_state;
  pts_tx_state_t tx_state;
  logic [2:0] rx_cnt;
  logic [2:0] tx_cnt;
  logic rx_first;
  logic [PTS_SEC_W-1:0] stamp_sec;
  logic [PTS_NS_W-1:0] stamp_ns;
  logic [PTS_CF_W-1:0] stamp_cf;
  logic stamp_is_cf;
  logic [63:0] rx_inline_word;
  logic [PTS_NS_W-1:0] next_ns;
  logic [PTS_SEC_W-1:0] next_sec;
  logic [PTS_CF_W-1:0] next_cf;
  logic [63:0] tx_cmd_sr;
  logic tx_take;
  logic tx_fwd;
  logic apb_wr;
  logic apb_rd_setup;

  pts_cmd_if cmd ();

  // apb: zero wait states, read data registered in the setup phase
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd_setup = psel & ~penable & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cfg_inline <= 1'b0;
      rx_cfg_cf <= 1'b0;
      tx_cfg_inline <= 1'b0;
      rx_latency <= RX_LAT_RESET;
    end else if (apb_wr) begin
      case (paddr)
        PTS_ADDR_RX_CFG: begin
          rx_cfg_inline <= pwdata[PTS_CFG_INLINE_BIT];
          rx_cfg_cf <= pwdata[PTS_RX_CFG_CF_BIT];
        end
        PTS_ADDR_TX_CFG: tx_cfg_inline <= pwdata[PTS_CFG_INLINE_BIT];
        PTS_ADDR_RX_LATENCY: rx_latency <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_rd_setup) begin
      prdata <= 32'h0;
      case (paddr)
        PTS_ADDR_RX_CFG: begin
          prdata[PTS_CFG_INLINE_BIT] <= rx_cfg_inline;
          prdata[PTS_RX_CFG_CF_BIT] <= rx_cfg_cf;
        end
        PTS_ADDR_TX_CFG: prdata[PTS_CFG_INLINE_BIT] <= tx_cfg_inline;
        PTS_ADDR_RX_LATENCY: prdata <= rx_latency;
        PTS_ADDR_STATUS: begin
          prdata[PTS_STAT_RX_BUSY_BIT] <= (rx_state != RX_IDLE);
          prdata[PTS_STAT_TX_BUSY_BIT] <= (tx_state != TX_IDLE);
          prdata[PTS_STAT_TAG_LSB +: 16] <= tx_cmd_tag;
        end
        PTS_ADDR_RX_FRAMES: prdata <= rx_frames;
        default: ;
      endcase
    end
  end

  // latency subtraction with borrow across the second boundary
  always_comb begin
    if (tod_ns >= rx_latency) begin
      next_ns = tod_ns - rx_latency;
      next_sec = tod_sec;
    end else begin
      next_ns = tod_ns + (PTS_NS_PER_SEC - rx_latency);
      next_sec = tod_sec - {{(PTS_SEC_W-1){1'b0}}, 1'b1};
    end
    next_cf = cf_time - {{(PTS_CF_W-PTS_NS_W-PTS_CF_FRAC_W){1'b0}}, rx_latency,
      {PTS_CF_FRAC_W{1'b0}}};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_sec <= '0;
      stamp_ns <= '0;
      stamp_cf <= '0;
      stamp_is_cf <= 1'b0;
    end else if (rx_capture) begin
      stamp_sec <= next_sec;
      stamp_ns <= next_ns;
      stamp_cf <= next_cf;
      stamp_is_cf <= rx_cfg_cf;
    end
  end

  assign rx_inline_word = stamp_is_cf ? stamp_cf : {stamp_sec[PTS_NS_W-1:0], stamp_ns};
  assign rx_in_ready = (rx_state == RX_PASS);

  // receive framing: optional eight stamp bytes ahead of the frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 3'h0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_cnt <= 3'h0;
          if (rx_in_valid) begin
            rx_state <= rx_cfg_inline ? RX_STAMP : RX_PASS;
          end
        end
        RX_STAMP: begin
          rx_cnt <= rx_cnt + 3'h1;
          if (rx_cnt == PTS_STAMP_LAST) begin
            rx_state <= RX_PASS;
          end
        end
        RX_PASS: begin
          if (rx_in_valid && rx_in_last) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_out_data <= 8'h0;
      rx_out_valid <= 1'b0;
      rx_out_last <= 1'b0;
    end else if (rx_state == RX_STAMP) begin
      rx_out_data <= rx_inline_word[{PTS_STAMP_LAST - rx_cnt, 3'h0} +: 8];
      rx_out_valid <= 1'b1;
      rx_out_last <= 1'b0;
    end else begin
      rx_out_data <= rx_in_data;
      rx_out_valid <= rx_in_valid & rx_in_ready;
      rx_out_last <= rx_in_valid & rx_in_ready & rx_in_last;
    end
  end

  // out of band stamp: one pulse alongside the first frame byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_first <= 1'b0;
      rx_stamp_stream_valid <= 1'b0;
      rx_stamp_stream_payload <= '0;
      rx_frames <= 32'h0;
    end else begin
      rx_stamp_stream_valid <= 1'b0;
      if (rx_state == RX_IDLE && rx_in_valid) begin
        rx_first <= 1'b1;
      end else if (rx_state == RX_PASS && rx_in_valid && rx_first) begin
        rx_first <= 1'b0;
        rx_stamp_stream_valid <= 1'b1;
        rx_frames <= rx_frames + 32'h1;
        rx_stamp_stream_payload <= '0;
        if (stamp_is_cf) begin
          rx_stamp_stream_payload[PTS_CF_W-1:0] <= stamp_cf;
        end else begin
          rx_stamp_stream_payload[PTS_SEC_LSB +: PTS_SEC_W] <= stamp_sec;
          rx_stamp_stream_payload[PTS_NS_W-1:0] <= stamp_ns;
        end
      end
    end
  end

  // transmit intake: command from sideband bits or the first eight bytes
  assign tx_fwd = (tx_state == TX_PASS) || (tx_state == TX_IDLE && !tx_cfg_inline);
  assign tx_in_ready = tx_fwd ? (!tx_out_valid || tx_out_ready) : 1'b1;
  assign tx_take = tx_in_valid & tx_in_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      tx_cnt <= 3'h0;
      tx_cmd_sr <= 64'h0;
    end else if (tx_take) begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_cfg_inline) begin
            tx_state <= TX_CMD;
            tx_cnt <= 3'h1;
            tx_cmd_sr <= {tx_in_data, tx_cmd_sr[63:8]};
          end else if (!tx_in_last) begin
            tx_state <= TX_PASS;
          end
        end
        TX_CMD: begin
          tx_cnt <= tx_cnt + 3'h1;
          tx_cmd_sr <= {tx_in_data, tx_cmd_sr[63:8]};
          if (tx_in_last) begin
            tx_state <= TX_IDLE;
          end else if (tx_cnt == PTS_STAMP_LAST) begin
            tx_state <= TX_PASS;
          end
        end
        TX_PASS: begin
          if (tx_in_last) begin
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd.load <= 1'b0;
      cmd.field <= 64'h0;
    end else begin
      cmd.load <= 1'b0;
      if (tx_take && tx_state == TX_IDLE && !tx_cfg_inline) begin
        cmd.load <= 1'b1;
        cmd.field <= tx_in_user[PTS_TUSER_CMD_LSB +: 64];
      end else if (tx_take && tx_state == TX_CMD && tx_cnt == PTS_STAMP_LAST) begin
        cmd.load <= 1'b1;
        cmd.field <= {tx_in_data, tx_cmd_sr[63:8]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out_data <= 8'h0;
      tx_out_valid <= 1'b0;
      tx_out_last <= 1'b0;
      tx_out_underrun <= 1'b0;
    end else if (tx_take && tx_fwd) begin
      tx_out_data <= tx_in_data;
      tx_out_valid <= 1'b1;
      tx_out_last <= tx_in_last;
      tx_out_underrun <= tx_in_user[PTS_TUSER_UNDERRUN];
    end else if (tx_out_ready) begin
      tx_out_valid <= 1'b0;
    end
  end

  pts_cmd_decode u_decode (
    .pclk (pclk),
    .presetn (presetn),
    .cmd (cmd)
  );

  assign tx_cmd_valid = cmd.valid;
  assign tx_cmd_op = cmd.op;
  assign tx_cmd_tag = cmd.tag;
  assign tx_cmd_offset = cmd.offset;
  assign tx_cmd_csum_update = cmd.csum_update;
  assign tx_cmd_csum_offset = cmd.csum_offset;

  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_STAMP_ONE_CYCLE: assert property (
    rx_stamp_stream_valid |=> !rx_stamp_stream_valid)
    else $error("stamp valid held longer than one cycle");
  AST_STAMP_WITH_FIRST: assert property (
    rx_stamp_stream_valid |-> rx_out_valid && $past(rx_state) == RX_PASS)
    else $error("stamp valid not on first frame word");
  AST_INLINE_EIGHT: assert property (
    rx_state == RX_IDLE && rx_in_valid && rx_cfg_inline
    |=> (rx_state == RX_STAMP && !rx_in_ready) [*8] ##1 rx_state == RX_PASS)
    else $error("in-line stamp is not eight bytes");
  AST_NO_STAMP_WHEN_OFF: assert property (
    rx_state == RX_IDLE && rx_in_valid && !rx_cfg_inline |=> rx_state == RX_PASS)
    else $error("stamp bytes sent while in-line stamping is off");
  AST_NS_ADJUST: assert property (
    rx_capture && tod_ns >= rx_latency
    |=> stamp_ns == $past(tod_ns) - $past(rx_latency) && stamp_sec == $past(tod_sec))
    else $error("captured stamp not reduced by latency");
  AST_PAYLOAD_LAYOUT: assert property (
    rx_stamp_stream_valid && !stamp_is_cf
    |-> rx_stamp_stream_payload[PTS_SEC_LSB +: PTS_SEC_W] == stamp_sec
      && rx_stamp_stream_payload[PTS_NS_W-1:0] == stamp_ns
      && rx_stamp_stream_payload[127:PTS_SEC_LSB+PTS_SEC_W] == '0)
    else $error("stamp payload fields misplaced");
  AST_CMD_SIDEBAND: assert property (
    tx_take && tx_state == TX_IDLE && !tx_cfg_inline
    |=> cmd.load && cmd.field == $past(tx_in_user[PTS_TUSER_CMD_LSB +: 64]) ##1 tx_cmd_valid)
    else $error("sideband command not taken on first word");
  AST_CMD_INLINE_MODE: assert property (
    tx_take && tx_state == TX_IDLE && tx_cfg_inline |=> tx_state == TX_CMD && !cmd.load)
    else $error("in-line command mode not entered");
endmodule // pts_top
`default_nettype wire

// ### pts_client_model.sv
// pts_client_model: client transmit source that feeds one frame per start pulse
// assumes the pclk domain; start is a one-cycle pulse from the bench
`timescale 1ns/10ps
`default_nettype none
module pts_client_model
  import pts_pkg::*;
(
  // control from bench
  input wire logic pclk,
  input wire logic start,
  input wire logic inline_mode,
  input wire logic [63:0] cmd,
  input wire logic [3:0] len,
  // transmit stream
  output logic [7:0] tx_in_data = 8'h00,
  output logic tx_in_valid = 1'b0,
  output logic tx_in_last = 1'b0,
  output logic [PTS_TUSER_W-1:0] tx_in_user = '0,
  input wire logic tx_in_ready
);
  int i;
  int n;
  int w;
  logic [63:0] side;
  always begin
    @(posedge pclk);
    if (start) begin
      n = inline_mode ? int'(len) + 8 : int'(len);
      for (i = 0; i < n; i++) begin
        // in-line command leads the frame, low byte first
        tx_in_data <= (inline_mode && i < 8) ? cmd[8*i +: 8] : 8'ha0 + 8'(i - (inline_mode ? 8 : 0));
        tx_in_valid <= 1'b1;
        tx_in_last <= (i == n - 1);
        // sideband command only on the first word; spare bits churn; last word flags underrun
        side = (!inline_mode && i == 0) ? cmd : ~cmd;
        tx_in_user <= {side, {63{i[0]}}, i == n - 1};
        @(negedge pclk);
        for (w = 0; w < 200 && !tx_in_ready; w++) @(negedge pclk);
        @(posedge pclk);
      end
      tx_in_valid <= 1'b0;
      tx_in_last <= 1'b0;
    end
  end
endmodule // pts_client_model
`default_nettype wire

// ### tb_top.sv
// tb_top: self-checking bench for pts_top over apb and its frame streams
// assumes pts_pkg and pts_client_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pts_pkg::*;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00, rx_in_data = 8'h00, rx_out_data, tx_in_data, tx_out_data;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [PTS_SEC_W-1:0] tod_sec = 48'h0000_1234_5678;
  logic [PTS_NS_W-1:0] tod_ns = 32'h0000_0010;
  logic [PTS_CF_W-1:0] cf_time = 64'h0123_4567_89ab_cdef;
  logic rx_capture = 1'b0, rx_in_valid = 1'b0, rx_in_last = 1'b0, rx_in_ready;
  logic rx_out_valid, rx_out_last, rx_stamp_stream_valid, tx_in_valid, tx_in_last, tx_in_ready;
  logic [127:0] rx_stamp_stream_payload, stamp;
  logic [PTS_TUSER_W-1:0] tx_in_user;
  logic tx_out_valid, tx_out_last, tx_out_underrun, tx_out_ready = 1'b1, tx_cmd_valid;
  pts_op_t tx_cmd_op, got_op;
  logic [15:0] tx_cmd_tag, tx_cmd_offset, tx_cmd_csum_offset, got_tag, got_ofs, got_cso;
  logic tx_cmd_csum_update, got_csu, start = 1'b0, inline_mode = 1'b0, stall = 1'b0;
  logic [63:0] cmd = 64'h0;
  logic [3:0] len = 4'h4;
  logic [79:0] ex;
  logic [9:0] rxq[$];
  logic [9:0] txq[$];
  int miscompares = 0, checked = 0, ncmd = 0, k;

  pts_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tod_sec, .tod_ns, .cf_time, .rx_capture, .rx_in_data, .rx_in_valid, .rx_in_last,
    .rx_in_ready, .rx_out_data, .rx_out_valid, .rx_out_last, .rx_stamp_stream_payload,
    .rx_stamp_stream_valid, .tx_in_data, .tx_in_valid, .tx_in_last, .tx_in_user, .tx_in_ready,
    .tx_out_data, .tx_out_valid, .tx_out_last, .tx_out_underrun, .tx_out_ready, .tx_cmd_valid,
    .tx_cmd_op, .tx_cmd_tag, .tx_cmd_offset, .tx_cmd_csum_update, .tx_cmd_csum_offset);
  pts_client_model client_u (.pclk, .start, .inline_mode, .cmd, .len, .tx_in_data, .tx_in_valid,
    .tx_in_last, .tx_in_user, .tx_in_ready);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // stream monitors; the mac side stalls every other cycle when asked
  always @(posedge pclk) begin
    if (rx_out_valid || rx_stamp_stream_valid) begin
      rxq.push_back({rx_out_last, rx_stamp_stream_valid, rx_out_data});
    end
    if (rx_stamp_stream_valid) stamp = rx_stamp_stream_payload;
    if (tx_out_valid && tx_out_ready) txq.push_back({tx_out_last, tx_out_underrun, tx_out_data});
    if (tx_cmd_valid) begin
      ncmd++;
      got_csu = tx_cmd_csum_update;
      got_cso = tx_cmd_csum_offset;
      got_op = tx_cmd_op;
      got_tag = tx_cmd_tag;
      got_ofs = tx_cmd_offset;
    end
    tx_out_ready <= stall ? ~tx_out_ready : 1'b1;
  end

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wrap_up;
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task give_up;
    miscompares++;
    $display("mismatch wait expected handshake seen none");
    wrap_up();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int w;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (w = 0; w < 100; w++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (w == 100) give_up();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(nm, q, x);
    check({nm, " error"}, e, xe);
  endtask

  function automatic logic [79:0] adj(input logic [47:0] s, input logic [31:0] ns,
      input logic [31:0] l);
    if (ns >= l) return {s, ns - l};
    return {s - 48'h1, ns + PTS_NS_PER_SEC - l};
  endfunction

  task automatic rx_frame(input int n);
    int i;
    int w;
    @(posedge pclk);
    rx_capture <= 1'b1;
    @(posedge pclk);
    rx_capture <= 1'b0;
    for (i = 0; i < n; i++) begin
      rx_in_valid <= 1'b1;
      rx_in_data <= 8'h10 + 8'(i);
      rx_in_last <= (i == n - 1);
      for (w = 0; w < 50; w++) begin
        @(negedge pclk);
        if (rx_in_ready === 1'b1) break;
      end
      if (w == 50) give_up();
      @(posedge pclk);
    end
    rx_in_valid <= 1'b0;
    rx_in_last <= 1'b0;
  endtask

  task automatic rx_check(input logic [63:0] inl, input int k, input int n,
      input logic [127:0] pexp);
    int i;
    int w;
    for (w = 0; w < 100 && rxq.size() < n + k; w++) @(posedge pclk);
    check("rx byte count", rxq.size(), n + k);
    for (i = 0; i < n + k && i < rxq.size(); i++) begin
      if (i < k) check("rx inline stamp byte", rxq[i], {2'b00, inl[63-8*i -: 8]});
      else check("rx byte", rxq[i], {i == n+k-1, i == k, 8'h10+8'(i-k)});
    end
    check("rx stamp payload", stamp, pexp);
    rxq.delete();
    stamp = '0;
  endtask

  task automatic tx_frame(input logic il, input logic [63:0] c);
    int w;
    int i;
    pts_op_t eo;
    txq.delete();
    ncmd = 0;
    @(posedge pclk);
    inline_mode <= il;
    cmd <= c;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    for (w = 0; w < 200 && (txq.size() < 4 || ncmd < 1); w++) @(posedge pclk);
    if (w == 200) give_up();
    eo = c[1:0] == PTS_OPC_ONE_STEP ? PTS_OP_ONE_STEP :
      c[1:0] == PTS_OPC_TWO_STEP ? PTS_OP_TWO_STEP : PTS_OP_NONE;
    check("tx op", got_op, eo);
    check("tx tag", got_tag, eo == PTS_OP_NONE ? 16'h0 : c[31:16]);
    check("tx offset", got_ofs, eo == PTS_OP_ONE_STEP ? c[47:32] : 16'h0);
    check("tx csum flag", got_csu, eo == PTS_OP_ONE_STEP && c[8]);
    check("tx csum offset", got_cso, eo == PTS_OP_ONE_STEP && c[8] ? c[63:48] : 16'h0);
    check("tx commands", ncmd, 1);
    for (i = 0; i < 4; i++) begin
      check("tx byte", txq[i], {i == 3, i == 3, 8'ha0 + 8'(i)});
    end
  endtask

  initial begin
    #2_000_000;
    give_up();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd("rx config", PTS_ADDR_RX_CFG, 32'h0, 1'b0);
    rd("tx config", PTS_ADDR_TX_CFG, 32'h0, 1'b0);
    rd("rx latency", PTS_ADDR_RX_LATENCY, 32'h0000_0040, 1'b0);
    rd("unmapped", 8'h20, 32'h0, 1'b1);
    wr(PTS_ADDR_STATUS, 32'hffff_ffff);
    rd("status", PTS_ADDR_STATUS, 32'h0, 1'b0);
    // latency above the nanoseconds count forces a seconds borrow
    wr(PTS_ADDR_RX_LATENCY, 32'h0000_0100);
    ex = adj(tod_sec, tod_ns, 32'h0000_0100);
    rx_frame(3);
    rx_check(64'h0, 0, 3, {48'h0, ex});
    // nanoseconds above the latency: no borrow
    tod_ns <= 32'h0000_0500;
    ex = adj(tod_sec, 32'h0000_0500, 32'h0000_0100);
    wr(PTS_ADDR_RX_CFG, 32'h0040_0000);
    rx_frame(2);
    rx_check(ex[63:0], 8, 2, {48'h0, ex});
    wr(PTS_ADDR_RX_CFG, 32'h0040_0001);
    ex = {16'h0, cf_time - 64'h0000_0000_0100_0000};
    rx_frame(1);
    rx_check(ex[63:0], 8, 1, {64'h0, ex[63:0]});
    rd("rx frames", PTS_ADDR_RX_FRAMES, 32'h3, 1'b0);
    wr(PTS_ADDR_RX_CFG, 32'h0);
    stall <= 1'b1;
    for (k = 0; k < 4; k++) begin
      tx_frame(1'b0, {16'h1234, 16'h0020 + 16'(k), 16'hc0de + 16'(k), 14'h2a5a, 2'(k)});
    end
    wr(PTS_ADDR_TX_CFG, 32'h0040_0000);
    tx_frame(1'b1, {16'h0, 16'h0044, 16'h7e57, 14'h0, 2'b01});
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
